// ---- msic_defines.vh ----
// constants for the interrupt capability register block
`ifndef MSIC_DEFINES_VH
`define MSIC_DEFINES_VH

// register byte offsets
`define MSIC_OFS_CAP_CTRL    12'h0D0
`define MSIC_OFS_ADDR_LO     12'h0D4
`define MSIC_OFS_ADDR_HI     12'h0D8
`define MSIC_OFS_MSG_DATA    12'h0DC
`define MSIC_OFS_LOCK        12'h0E0
`define MSIC_OFS_IRQ_STATUS  12'h0E4
`define MSIC_OFS_IRQ_MASK    12'h0E8
`define MSIC_OFS_SS_CAP      12'h0F0
`define MSIC_OFS_SS_IDENT    12'h0F4

// fixed identifiers and field values
`define MSIC_CAPABILITY_IDENTIFIER_MSI       8'h05
`define MSIC_CAPABILITY_IDENTIFIER_SS        8'h0D
`define MSIC_PTR_RESET       8'h00
`define MSIC_REQ_COUNT       3'h0
`define MSIC_WIDE_CAPABLE    1'h1
`define MSIC_IDENT_RESET     16'h0000

// field positions
`define MSIC_EN_BIT          16
`define MSIC_GRANT_LO        20
`define MSIC_GRANT_HI        22
`define MSIC_ADDR_LO_BIT     2
`define MSIC_LOCK_BIT        0
`define MSIC_ID_HI           7
`define MSIC_PTR_LO          8
`define MSIC_PTR_HI          15
`define MSIC_REQ_LO          17
`define MSIC_REQ_HI          19
`define MSIC_WIDE_BIT        23

// sticky event bits: sent, dropped while disabled, merged while pending
`define MSIC_EVT_W           3
`define MSIC_EVT_SENT        0
`define MSIC_EVT_DROP        1
`define MSIC_EVT_MERGE       2

`endif

// ---- msic_regs.v ----
// interrupt capability and subsystem identification registers with apb access
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "msic_defines.vh"

//Contract
// - interrupt capability low byte reads fixed identifier 0x5
// - interrupt chain pointer resets to zero, writable only when unlocked
// - enable bit resets to zero and gates interrupt message generation
// - requested message count is read-only and reads zero
// - granted count treated as one message; only one vector ever issued
// - wide address capable flag reads one, read-only
// - lower address keeps bits 31:2 writable, bits 1:0 read zero
// - non-zero upper address makes the write use a 64-bit address
// - zero upper address makes the write use the 32-bit lower address
// - message payload is 16 writable bits, upper half reads zero
// - subsystem capability reads identifier 0xD, lockable pointer resets zero
// - subsystem vendor code low half, resets zero, writable only unlocked
// - subsystem code high half, lockable, resets zero
module msic_regs #(
    parameter ADDR_W = 12
) (
    // apb clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // apb slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    input  wire [3:0]        pstrb,
    output reg               pready,
    output reg  [31:0]       prdata,
    output reg               pslverr,
    // interrupt source, same clock domain
    input  wire              event_pulse,
    // posted memory write request toward the root port
    output reg               mwr_valid,
    input  wire              mwr_ready,
    output reg  [63:0]       mwr_addr,
    output reg               mwr_wide,
    output reg  [31:0]       mwr_data,
    // level interrupt to local processor
    output reg               irq
);

    // byte-enable merge, used for every writable register
    function [31:0] merge_bytes;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  strb;
        integer      i;
        begin
            merge_bytes = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge_bytes[8*i +: 8] = new_val[8*i +: 8];
                end
            end
        end
    endfunction

    // write-one-to-clear with set winning over clear
    function [`MSIC_EVT_W-1:0] sticky_next;
        input [`MSIC_EVT_W-1:0] cur;
        input [`MSIC_EVT_W-1:0] clr;
        input [`MSIC_EVT_W-1:0] set;
        begin
            sticky_next = (cur & ~clr) | set;
        end
    endfunction

    // words that answer; anything else gets an error response
    function ofs_mapped;
        input [11:0] ofs;
        begin
            case (ofs)
                `MSIC_OFS_CAP_CTRL,
                `MSIC_OFS_ADDR_LO,
                `MSIC_OFS_ADDR_HI,
                `MSIC_OFS_MSG_DATA,
                `MSIC_OFS_LOCK,
                `MSIC_OFS_IRQ_STATUS,
                `MSIC_OFS_IRQ_MASK,
                `MSIC_OFS_SS_CAP,
                `MSIC_OFS_SS_IDENT: begin
                    ofs_mapped = 1'b1;
                end
                default: begin
                    ofs_mapped = 1'b0;
                end
            endcase
        end
    endfunction

    // stored register fields
    reg  [7:0]              cap_ptr;
    reg                     msg_enable;
    reg  [2:0]              granted_vector_count;
    reg  [29:0]             addr_low;
    reg  [31:0]             upper_target_address;
    reg  [15:0]             message_payload;
    reg  [7:0]              ss_ptr;
    reg  [15:0]             subsystem_vendor_code;
    reg  [15:0]             subsystem_code;
    reg                     write_lock;
    reg  [`MSIC_EVT_W-1:0]  evt_status;
    reg  [`MSIC_EVT_W-1:0]  evt_mask;
    reg  [2:0]              msg_state;
    reg  [2:0]              next_msg_state;

    // decoded bus phases
    wire [11:0]             reg_ofs;
    wire                    access_done;
    wire                    wr_go;
    wire                    mapped;
    reg  [31:0]             rd_value;

    // only the low twelve address bits select a word
    assign reg_ofs     = paddr[11:0];
    assign access_done = psel & penable & pready;
    assign wr_go       = access_done & pwrite;

    // address decode; unmapped words answer with an error
    assign mapped = ofs_mapped(reg_ofs);

    // read data assembly; reserved bits read zero
    always @* begin
        rd_value = 32'h00000000;
        case (reg_ofs)
            `MSIC_OFS_CAP_CTRL: begin
                rd_value[`MSIC_ID_HI:0] = `MSIC_CAPABILITY_IDENTIFIER_MSI;
                rd_value[`MSIC_PTR_HI:`MSIC_PTR_LO] = cap_ptr;
                rd_value[`MSIC_EN_BIT] = msg_enable;
                rd_value[`MSIC_REQ_HI:`MSIC_REQ_LO] = `MSIC_REQ_COUNT;
                rd_value[`MSIC_GRANT_HI:`MSIC_GRANT_LO] = granted_vector_count;
                rd_value[`MSIC_WIDE_BIT] = `MSIC_WIDE_CAPABLE;
            end
            `MSIC_OFS_ADDR_LO: begin
                rd_value[31:`MSIC_ADDR_LO_BIT] = addr_low;
            end
            `MSIC_OFS_ADDR_HI: begin
                rd_value = upper_target_address;
            end
            `MSIC_OFS_MSG_DATA: begin
                rd_value[15:0] = message_payload;
            end
            `MSIC_OFS_LOCK: begin
                rd_value[`MSIC_LOCK_BIT] = write_lock;
            end
            `MSIC_OFS_IRQ_STATUS: begin
                rd_value[`MSIC_EVT_W-1:0] = evt_status;
            end
            `MSIC_OFS_IRQ_MASK: begin
                rd_value[`MSIC_EVT_W-1:0] = evt_mask;
            end
            `MSIC_OFS_SS_CAP: begin
                rd_value[`MSIC_ID_HI:0] = `MSIC_CAPABILITY_IDENTIFIER_SS;
                rd_value[`MSIC_PTR_HI:`MSIC_PTR_LO] = ss_ptr;
            end
            `MSIC_OFS_SS_IDENT: begin
                rd_value[15:0]  = subsystem_vendor_code;
                rd_value[31:16] = subsystem_code;
            end
            default: begin
                rd_value = 32'h00000000;
            end
        endcase
    end

    // one wait state: ready rises in the cycle after the first access cycle, read data captured with it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            // error flag only alongside ready, so it never leaks into the next transfer
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                prdata  <= pwrite ? 32'h00000000 : rd_value;
                pslverr <= ~mapped;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // merged write values, computed once per access
    wire [31:0] wr_cap;
    wire [31:0] wr_lo;
    wire [31:0] wr_hi;
    wire [31:0] wr_msg;
    wire [31:0] wr_ss_cap;
    wire [31:0] wr_ss_id;
    wire [31:0] wr_lock;
    wire [31:0] wr_mask;
    wire [31:0] wr_stat;

    // each write except to the status word merges over the word as it reads back now
    assign wr_cap    = merge_bytes({8'h00, 1'b0, granted_vector_count, 3'h0, msg_enable,
                                    cap_ptr, 8'h00}, pwdata, pstrb);
    assign wr_lo     = merge_bytes({addr_low, 2'b00}, pwdata, pstrb);
    assign wr_hi     = merge_bytes(upper_target_address, pwdata, pstrb);
    assign wr_msg    = merge_bytes({16'h0000, message_payload}, pwdata, pstrb);
    assign wr_ss_cap = merge_bytes({16'h0000, ss_ptr, 8'h00}, pwdata, pstrb);
    assign wr_ss_id  = merge_bytes({subsystem_code, subsystem_vendor_code}, pwdata, pstrb);
    assign wr_lock   = merge_bytes({31'h00000000, write_lock}, pwdata, pstrb);
    assign wr_mask   = merge_bytes({29'h00000000, evt_mask}, pwdata, pstrb);
    // status clear only from bytes actually enabled
    assign wr_stat   = merge_bytes(32'h00000000, pwdata, pstrb);

    // configuration register writes; locked fields ignore software while lock is set
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_ptr               <= `MSIC_PTR_RESET;
            msg_enable            <= 1'b0;
            granted_vector_count  <= 3'h0;
            addr_low              <= 30'h00000000;
            upper_target_address  <= 32'h00000000;
            message_payload       <= 16'h0000;
            ss_ptr                <= `MSIC_PTR_RESET;
            subsystem_vendor_code <= `MSIC_IDENT_RESET;
            subsystem_code        <= `MSIC_IDENT_RESET;
            write_lock            <= 1'b0;
            evt_mask              <= {`MSIC_EVT_W{1'b0}};
        end else if (wr_go) begin
            case (reg_ofs)
                `MSIC_OFS_CAP_CTRL: begin
                    if (!write_lock) begin
                        cap_ptr <= wr_cap[`MSIC_PTR_HI:`MSIC_PTR_LO];
                    end
                    msg_enable <= wr_cap[`MSIC_EN_BIT];
                    // stored for readback only; hardware still uses a single vector
                    granted_vector_count <= wr_cap[`MSIC_GRANT_HI:`MSIC_GRANT_LO];
                end
                `MSIC_OFS_ADDR_LO: begin
                    addr_low <= wr_lo[31:`MSIC_ADDR_LO_BIT];
                end
                `MSIC_OFS_ADDR_HI: begin
                    upper_target_address <= wr_hi;
                end
                `MSIC_OFS_MSG_DATA: begin
                    message_payload <= wr_msg[15:0];
                end
                `MSIC_OFS_LOCK: begin
                    write_lock <= wr_lock[`MSIC_LOCK_BIT];
                end
                `MSIC_OFS_IRQ_MASK: begin
                    evt_mask <= wr_mask[`MSIC_EVT_W-1:0];
                end
                `MSIC_OFS_SS_CAP: begin
                    if (!write_lock) begin
                        ss_ptr <= wr_ss_cap[`MSIC_PTR_HI:`MSIC_PTR_LO];
                    end
                end
                `MSIC_OFS_SS_IDENT: begin
                    if (!write_lock) begin
                        subsystem_vendor_code <= wr_ss_id[15:0];
                        subsystem_code        <= wr_ss_id[31:16];
                    end
                end
                default: begin
                    cap_ptr <= cap_ptr;
                end
            endcase
        end
    end

    // message issue: one request out and one waiting at most, later events merged
    localparam [2:0] MS_IDLE      = 3'b001;
    localparam [2:0] MS_SEND      = 3'b010;
    localparam [2:0] MS_SEND_PEND = 3'b100;

    wire msg_taken;
    wire issue_now;
    wire evt_accept;
    wire msg_pending;

    assign msg_taken   = mwr_valid & mwr_ready;
    assign evt_accept  = event_pulse & msg_enable;
    assign msg_pending = (msg_state == MS_SEND_PEND);
    // a waiting event launches on the very edge that frees the link
    assign issue_now   = (msg_pending | evt_accept) & (~mwr_valid | msg_taken);

    // next state; a single waiting slot keeps the cost to one flag's worth
    always @* begin
        next_msg_state = msg_state;
        case (msg_state)
            MS_IDLE: begin
                if (evt_accept) begin
                    next_msg_state = MS_SEND;
                end
            end
            MS_SEND: begin
                if (msg_taken) begin
                    next_msg_state = evt_accept ? MS_SEND : MS_IDLE;
                end else if (evt_accept) begin
                    next_msg_state = MS_SEND_PEND;
                end
            end
            MS_SEND_PEND: begin
                // taken with a fresh event: the fresh one refills the waiting slot
                if (msg_taken && !evt_accept) begin
                    next_msg_state = MS_SEND;
                end
            end
            default: begin
                next_msg_state = MS_IDLE;
            end
        endcase
    end

    // message state register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_state <= MS_IDLE;
        end else begin
            msg_state <= next_msg_state;
        end
    end

    // posted write request held stable until the link accepts it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mwr_valid <= 1'b0;
            mwr_addr  <= 64'h0000000000000000;
            mwr_wide  <= 1'b0;
            mwr_data  <= 32'h00000000;
        end else if (issue_now) begin
            // fields frozen here; later register writes leave an issued request alone
            mwr_valid <= 1'b1;
            if (|upper_target_address) begin
                mwr_addr <= {upper_target_address, addr_low, 2'b00};
                mwr_wide <= 1'b1;
            end else begin
                mwr_addr <= {32'h00000000, addr_low, 2'b00};
                mwr_wide <= 1'b0;
            end
            // single vector: payload never altered by the granted count
            mwr_data <= {16'h0000, message_payload};
        end else if (msg_taken) begin
            mwr_valid <= 1'b0;
        end
    end

    // sticky event status, interrupt level from next status and mask
    reg  [`MSIC_EVT_W-1:0] evt_set;
    wire [`MSIC_EVT_W-1:0] evt_clr;
    wire [`MSIC_EVT_W-1:0] next_status;

    always @* begin
        evt_set = {`MSIC_EVT_W{1'b0}};
        evt_set[`MSIC_EVT_SENT]  = msg_taken;
        evt_set[`MSIC_EVT_DROP]  = event_pulse & ~msg_enable;
        evt_set[`MSIC_EVT_MERGE] = evt_accept & msg_pending & ~issue_now;
    end

    // software clears only through the status word
    assign evt_clr = (wr_go && reg_ofs == `MSIC_OFS_IRQ_STATUS) ?
                     wr_stat[`MSIC_EVT_W-1:0] : {`MSIC_EVT_W{1'b0}};
    assign next_status = sticky_next(evt_status, evt_clr, evt_set);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status <= {`MSIC_EVT_W{1'b0}};
            irq        <= 1'b0;
        end else begin
            evt_status <= next_status;
            irq        <= |(next_status & evt_mask);
        end
    end

endmodule // msic_regs

// ---- msic_regs_asserts.sv ----
// port assertions for the interrupt capability registers
`timescale 1ns/1ps
module msic_regs_asserts #(
    parameter ADDR_W = 12
) (
    // apb side
    input wire              pclk,
    input wire              presetn,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire              pready,
    input wire [31:0]       prdata,
    // posted write side
    input wire              mwr_valid,
    input wire              mwr_ready,
    input wire [63:0]       mwr_addr,
    input wire              mwr_wide,
    input wire [31:0]       mwr_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // read answer in its ready cycle
    wire rd = pready && !pwrite;
    AST_PREADY_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after access cycle");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_CAP_FIXED: assert property (rd && paddr == 12'h0D0 |->
        prdata[7:0] == 8'h05 && prdata[19:17] == 3'h0 && prdata[23] && prdata[31:24] == 8'h00)
        else $error("cap word");
    AST_ADDR_LOW: assert property (rd && paddr == 12'h0D4 |-> prdata[1:0] == 2'h0)
        else $error("low address bits not zero");
    AST_DATA_HIGH: assert property (rd && paddr == 12'h0DC |-> prdata[31:16] == 16'h0)
        else $error("payload upper half not zero");
    AST_SS_FIXED: assert property (rd && paddr == 12'h0F0 |-> prdata[7:0] == 8'h0D
        && prdata[31:16] == 16'h0) else $error("subsystem cap word");
    // a stalled request must not move under the link
    AST_MWR_HOLD: assert property (mwr_valid && !mwr_ready |=> mwr_valid
        && $stable(mwr_addr) && $stable(mwr_data)) else $error("request changed while stalled");
    AST_MWR_FORM: assert property (mwr_valid |->
        mwr_wide == (mwr_addr[63:32] != 32'h0) && mwr_addr[1:0] == 2'h0
        && mwr_data[31:16] == 16'h0) else $error("request form");
    cover property (mwr_valid && mwr_ready && mwr_wide);
    cover property (mwr_valid && mwr_ready && !mwr_wide);
    cover property (mwr_valid && !mwr_ready ##1 mwr_valid);
endmodule // msic_regs_asserts

bind msic_regs msic_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .prdata(prdata), .mwr_valid(mwr_valid), .mwr_ready(mwr_ready), .mwr_addr(mwr_addr),
    .mwr_wide(mwr_wide), .mwr_data(mwr_data));

// ---- msic_root_model.sv ----
// root port model taking posted interrupt writes
`timescale 1ns/1ps
module msic_root_model (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // posted write request and stall length
    input  wire        mwr_valid,
    output reg         mwr_ready,
    input  wire [63:0] mwr_addr,
    input  wire        mwr_wide,
    input  wire [31:0] mwr_data,
    input  wire [3:0]  stall
);
    logic [63:0] q_addr[$];
    logic [31:0] q_data[$];
    logic        q_wide[$];
    logic [3:0]  cnt;
    // ready only under valid and after the stall, so no accept is ever early
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mwr_ready <= 1'b0;
            cnt       <= 4'h0;
        end else if (mwr_valid && mwr_ready) begin
            q_addr.push_back(mwr_addr);
            q_data.push_back(mwr_data);
            q_wide.push_back(mwr_wide);
            mwr_ready <= 1'b0;
            cnt       <= 4'h0;
        end else if (mwr_valid) begin
            mwr_ready <= cnt >= stall;
            cnt       <= cnt + 4'h1;
        end
    end
endmodule // msic_root_model

// ---- testbench.sv ----
// self-checking bench for the interrupt capability registers
`timescale 1ns/1ps
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, event_pulse, pready, pslverr;
    logic        mwr_valid, mwr_ready, mwr_wide, irq, xe, m_en, m_lk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, mwr_data, m_lo, m_hi, m_ss, x;
    logic [3:0]  pstrb, root_stall;
    logic [63:0] mwr_addr;
    logic [15:0] m_dat;
    logic [7:0]  m_ptr, m_sp;
    logic [2:0]  m_gr, m_st, m_mk;
    logic [11:0] ad[11];
    int          n_fail, checks_done, k, i;
    int          cyc = 0;
    msic_regs #(.ADDR_W(12)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .event_pulse(event_pulse),
        .mwr_valid(mwr_valid), .mwr_ready(mwr_ready), .mwr_addr(mwr_addr),
        .mwr_wide(mwr_wide), .mwr_data(mwr_data), .irq(irq));
    msic_root_model u_root (.pclk(pclk), .presetn(presetn), .mwr_valid(mwr_valid),
        .mwr_ready(mwr_ready), .mwr_addr(mwr_addr), .mwr_wide(mwr_wide),
        .mwr_data(mwr_data), .stall(root_stall));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // hang guard, far above the fewer than a thousand cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    task end_of_test();
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input [63:0] e, input [63:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // model read value; unmapped places answer zero with an error
    task mrd(input [11:0] a);
        x = 32'h0;
        xe = 1'b0;
        case (a)
            12'h0D0: x = {8'h00, 1'b1, m_gr, 3'h0, m_en, m_ptr, 8'h05};
            12'h0D4: x = m_lo;
            12'h0D8: x = m_hi;
            12'h0DC: x = {16'h0, m_dat};
            12'h0E0: x = {31'h0, m_lk};
            12'h0E4: x = {29'h0, m_st};
            12'h0E8: x = {29'h0, m_mk};
            12'h0F0: x = {16'h0, m_sp, 8'h0D};
            12'h0F4: x = m_ss;
            default: xe = 1'b1;
        endcase
    endtask
    // model update; strobe-off bytes keep old value, locked fields ignore writes
    task mw(input [11:0] a, input [31:0] d, input [3:0] s);
        logic [31:0] m, v;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        mrd(a);
        v = (x & ~m) | (d & m);
        case (a)
            12'h0D0: begin
                if (!m_lk) m_ptr = v[15:8];
                m_en = v[16];
                m_gr = v[22:20];
            end
            12'h0D4: m_lo = {v[31:2], 2'h0};
            12'h0D8: m_hi = v;
            12'h0DC: m_dat = v[15:0];
            12'h0E0: m_lk = v[0];
            12'h0E4: m_st = m_st & ~(d[2:0] & m[2:0]);
            12'h0E8: m_mk = v[2:0];
            12'h0F0: if (!m_lk) m_sp = v[15:8];
            12'h0F4: if (!m_lk) m_ss = v;
            default: ;
        endcase
    endtask
    // one apb transfer, held until pready, checked against the model
    task acc(input [11:0] a, input w, input [31:0] d, input [3:0] s);
        logic [31:0] r;
        logic        e;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= w ? s : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        mrd(a);
        chk("pslverr", xe, e);
        if (w) mw(a, d, s);
        else chk("prdata", x, r);
    endtask
    task irqchk();
        acc(12'h0E4, 1'b0, 32'h0, 4'h0);
        chk("irq", (m_st & m_mk) != 3'h0, irq);
    endtask
    // pulse the event n cycles, then compare what the root port took
    task msg(input int n, input [2:0] ev);
        int n0;
        int ne;
        n0 = u_root.q_addr.size();
        ne = m_en ? (n > 1 ? 2 : 1) : 0;
        event_pulse <= 1'b1;
        repeat (n) @(posedge pclk);
        event_pulse <= 1'b0;
        while (u_root.q_addr.size() < n0 + ne) @(posedge pclk);
        repeat (4) @(posedge pclk);
        m_st = m_st | ev;
        chk("mwr count", ne, u_root.q_addr.size() - n0);
        for (i = n0; i < n0 + ne; i++) begin
            chk("mwr addr", m_hi != 0 ? {m_hi, m_lo} : {32'h0, m_lo}, u_root.q_addr[i]);
            chk("mwr data", {16'h0, m_dat}, u_root.q_data[i]);
            chk("mwr wide", m_hi != 0, u_root.q_wide[i]);
        end
        irqchk();
    endtask
    initial begin
        {psel, penable, pwrite, event_pulse, presetn} = 5'h00;
        {paddr, pwdata, pstrb, root_stall} = 52'h0;
        {m_ptr, m_sp, m_en, m_lk, m_gr, m_st, m_mk} = 27'h0;
        {m_lo, m_hi, m_ss, m_dat} = 112'h0;
        ad = '{12'h0D0, 12'h0D4, 12'h0D8, 12'h0DC, 12'h0E0, 12'h0E4,
               12'h0E8, 12'h0F0, 12'h0F4, 12'h0C0, 12'h0FC};
        k = $urandom(32'hFB93);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, unmapped places included
        for (i = 0; i < 11; i++) acc(ad[i], 1'b0, 32'h0, 4'h0);
        $display("test reset_values done");
        // random data and strobes, lock bit landing at random too
        for (k = 0; k < 6; k++) begin
            for (i = 0; i < 11; i++) begin
                acc(ad[i], 1'b1, $urandom, 4'($urandom));
                acc(ad[i], 1'b0, 32'h0, 4'h0);
            end
        end
        $display("test random_access done");
        // narrow, wide, then merged under a stalling link
        acc(12'h0E0, 1'b1, 32'h0, 4'hF);
        acc(12'h0E8, 1'b1, 32'h7, 4'hF);
        acc(12'h0D0, 1'b1, 32'h0071_0000, 4'hF);
        acc(12'h0D8, 1'b1, 32'h0, 4'hF);
        acc(12'h0D4, 1'b1, $urandom, 4'hF);
        acc(12'h0DC, 1'b1, $urandom, 4'hF);
        msg(1, 3'h1);
        acc(12'h0E4, 1'b1, 32'h7, 4'hF);
        acc(12'h0D8, 1'b1, $urandom | 32'h1, 4'hF);
        msg(1, 3'h1);
        acc(12'h0E4, 1'b1, 32'h7, 4'hF);
        root_stall <= 4'h3;
        msg(3, 3'h5);
        acc(12'h0E4, 1'b1, 32'h7, 4'hF);
        irqchk();
        $display("test messages done");
        // disabled event is dropped, hidden until its mask bit opens
        acc(12'h0E8, 1'b1, 32'h0, 4'hF);
        acc(12'h0D0, 1'b1, 32'h0, 4'hF);
        msg(1, 3'h2);
        acc(12'h0E8, 1'b1, 32'h2, 4'hF);
        irqchk();
        acc(12'h0E4, 1'b1, 32'h7, 4'hF);
        irqchk();
        $display("test mask_drop done");
        // an event leaves status and irq up, then a reset in mid-run clears all
        msg(1, 3'h2);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        {m_ptr, m_sp, m_en, m_lk, m_gr, m_st, m_mk} = 27'h0;
        {m_lo, m_hi, m_ss, m_dat} = 112'h0;
        chk("irq", 1'b0, irq);
        for (i = 0; i < 11; i++) acc(ad[i], 1'b0, 32'h0, 4'h0);
        $display("test mid_reset done");
        end_of_test();
    end
endmodule // testbench
